// File: core/dbs_conv_if.sv
interface dbs_conv_if;
  import dbs_pkg::*;
  logic          wr;
  logic [SW-1:0] data;
  modport src (output wr, data);
  modport dst (input wr, data);
endinterface

// File: core/dbs_pingpong.sv
module dbs_pingpong
  import dbs_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  wire logic          srst,
  dbs_conv_if.dst            cv,
  input  wire logic [8:0]    thr,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [SW-1:0] rd_data,
  output logic               swap
);
  // ------------------------------------------------------------
  // two banks of samples, one filling and one readable
  // ------------------------------------------------------------
  logic [SW-1:0] mem_q [2*DEPTH];
  logic          fill_q, fill_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic [SW-1:0] rd_q;
  logic          swap_q, swap_d;

  // next fill pointer, count and swap
  always_comb begin
    fill_d = fill_q;
    cnt_d  = cnt_q;
    swap_d = 1'b0;
    if (srst) begin
      cnt_d = '0;
    end else if (cv.wr) begin
      if (cnt_q >= {1'b0, thr}) begin
        fill_d = ~fill_q;
        cnt_d  = '0;
        swap_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_q <= 1'b0;
      cnt_q  <= '0;
      swap_q <= 1'b0;
    end else begin
      fill_q <= fill_d;
      cnt_q  <= cnt_d;
      swap_q <= swap_d;
    end
  end

  // sample storage, no reset
  always_ff @(posedge ref_clk) begin
    if (cv.wr) begin
      mem_q[{fill_q, cnt_q[AW-1:0]}] <= cv.data;
    end
    if (rd_en) begin
      rd_q <= mem_q[{~fill_q, rd_addr}];
    end
  end

  assign rd_data = rd_q;
  assign swap    = swap_q;

  property p_swap_count;
    @(posedge ref_clk) disable iff (!arst_n)
      (cv.wr && !srst && cnt_q == {1'b0, thr}) |=> swap_q && cnt_q == 10'h000;
  endproperty
  a_swap_count: assert property (p_swap_count)
    else $error("swap not taken at threshold plus one");
endmodule

// File: core/dbs_pkg.sv
package dbs_pkg;
  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_IRQ   = 12'h000;
  localparam logic [11:0] OFS_CTRL  = 12'h004;
  localparam logic [11:0] OFS_CHSEL = 12'h008;
  localparam logic [11:0] OFS_RPT   = 12'h00c;
  localparam logic [11:0] OFS_DLY   = 12'h010;
  localparam logic [11:0] OFS_THR   = 12'h014;
  localparam logic [11:0] OFS_TRIG  = 12'h018;
  localparam logic [11:0] OFS_MEM   = 12'h800;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int          CTRL_VALID_BIT = 8;
  localparam int          CTRL_SRST_BIT  = 15;
  localparam int          CTRL_ASTOP_BIT = 6;
  localparam int          IRQ_EN_BIT     = 0;
  localparam int          IRQ_PEND_BIT   = 1;
  localparam int          IRQ_REL_BIT    = 15;
  localparam int          TRIG_GO_BIT    = 0;
  localparam logic [8:0]  THR_RESET      = 9'h1ff;
  localparam logic [6:0]  CTRL_RW_MASK   = 7'h7f;
  localparam int          NUM_CH         = 16;
  localparam int          BANK_CH        = 8;
  localparam int          DEPTH          = 512;
  localparam int          AW             = 9;
  localparam int          SW             = 20;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          CLK_HZ      = 10_000_000;
  localparam int          TICK_HZ     = 8_000_000;
  localparam int          SRST_NS     = 300;
  localparam int          CLK_NS      = 1_000_000_000 / CLK_HZ;
  localparam int          SRST_CYC    = (SRST_NS + CLK_NS - 1) / CLK_NS;

  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DBS_MODE_OFF  = 2'b00,
    DBS_MODE_ONE  = 2'b01,
    DBS_MODE_CONT = 2'b10,
    DBS_MODE_RSV  = 2'b11
  } dbs_mode_t;

  typedef enum logic [1:0] {
    DBS_XT_OFF = 2'b00,
    DBS_XT_IN  = 2'b01,
    DBS_XT_OUT = 2'b10,
    DBS_XT_RSV = 2'b11
  } dbs_xt_t;
endpackage

// File: core/dbs_seq.sv
module dbs_seq
  import dbs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [11:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [3:0]  bus_be,
  output logic      [31:0] bus_rdata,
  output logic             bus_rvalid,
  input  wire logic [15:0] adc_data,
  output logic      [3:0]  adc_ch,
  input  wire logic        ext_trig_in,
  output logic             ext_trig_out,
  output logic             ext_trig_oe,
  output logic             irq,
  output logic             board_rst
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DBS_ST_IDLE = 2'b00,
    DBS_ST_LOW  = 2'b01,
    DBS_ST_WAIT = 2'b10,
    DBS_ST_HIGH = 2'b11
  } dbs_st_t;

  logic [6:0]  ctrl_q, ctrl_d;
  logic        valid_q, valid_d;
  logic [15:0] chsel_q, chsel_d;
  logic [23:0] rpt_q, rpt_d, dly_q, dly_d;
  logic [8:0]  thr_q, thr_d;
  logic        ien_q, ien_d, pend_q, pend_d;
  logic [2:0]  srcnt_q, srcnt_d;
  logic [2:0]  tph_q, tph_d;
  logic [23:0] rcnt_q, rcnt_d, dcnt_q, dcnt_d;
  dbs_st_t     st_q, st_d;
  logic [3:0]  ch_q, ch_d;
  logic [2:0]  xs_q;
  logic        xtr_q, xtr_d, xo_q, xo_d;
  logic [31:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d, mrd_q, mrd_d;
  logic        srst, tick, swap, go, rpt_fire, ext_edge;
  logic [SW-1:0] mem_rd;
  dbs_mode_t   mode;
  dbs_xt_t     xt;
  dbs_conv_if  cv ();

  // byte-lane merge for host writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  assign srst = (srcnt_q != 3'h0);
  assign mode = dbs_mode_t'(ctrl_q[1:0]);
  assign xt   = dbs_xt_t'(ctrl_q[5:4]);
  // four ticks in every five clocks gives 8 MHz from 10 MHz
  assign tick = (tph_q != 3'h0);

  // ------------------------------------------------------------
  // trigger sources
  // ------------------------------------------------------------
  assign ext_edge = (xs_q[1] == xs_q[2]) && xs_q[2] && !xtr_q;
  assign go = (bus_wr && bus_addr == OFS_TRIG && bus_be[0] && bus_wdata[TRIG_GO_BIT])
           || (xt == DBS_XT_IN && ext_edge);
  assign rpt_fire = tick && rcnt_q == rpt_q && mode == DBS_MODE_CONT && st_q != DBS_ST_IDLE;

  // external pin synchroniser
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) xs_q <= 3'h0;
    else xs_q <= {xs_q[1:0], ext_trig_in};
  end

  // ------------------------------------------------------------
  // register file next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] m;
    m        = '0;
    ctrl_d   = ctrl_q;
    valid_d  = valid_q;
    chsel_d  = chsel_q;
    rpt_d    = rpt_q;
    dly_d    = dly_q;
    thr_d    = thr_q;
    ien_d    = ien_q;
    pend_d   = pend_q;
    srcnt_d  = (srcnt_q != 3'h0) ? srcnt_q - 3'h1 : 3'h0;
    if (bus_wr) begin
      unique case (bus_addr)
        OFS_IRQ: begin
          m = merge({16'h0, 15'h0, ien_q}, bus_wdata, bus_be);
          ien_d = m[IRQ_EN_BIT];
          if (m[IRQ_REL_BIT] && bus_be[1]) pend_d = 1'b0;
        end
        OFS_CTRL: begin
          m = merge({25'h0, ctrl_q}, bus_wdata, bus_be);
          ctrl_d = m[6:0] & CTRL_RW_MASK;
          if (m[CTRL_SRST_BIT] && bus_be[1]) srcnt_d = 3'(SRST_CYC);
        end
        OFS_CHSEL: begin
          m       = merge({16'h0, chsel_q}, bus_wdata, bus_be);
          chsel_d = m[15:0];
        end
        OFS_RPT: begin
          m     = merge({8'h0, rpt_q}, bus_wdata, bus_be);
          rpt_d = m[23:0];
        end
        OFS_DLY: begin
          m     = merge({8'h0, dly_q}, bus_wdata, bus_be);
          dly_d = m[23:0];
        end
        OFS_THR: begin
          m     = merge({23'h0, thr_q}, bus_wdata, bus_be);
          thr_d = m[8:0];
        end
        default: ;
      endcase
    end
    if (swap) begin
      valid_d = 1'b1;
      if (ien_q) pend_d = 1'b1;
      if (ctrl_q[CTRL_ASTOP_BIT]) ctrl_d[1:0] = DBS_MODE_OFF;
    end else if (mrd_q) begin
      valid_d = 1'b0;
    end
    if (srst) begin
      ctrl_d  = '0;
      valid_d = 1'b0;
      chsel_d = '0;
      rpt_d   = '0;
      dly_d   = '0;
      thr_d   = THR_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q  <= '0;
      valid_q <= 1'b0;
      chsel_q <= '0;
      rpt_q   <= '0;
      dly_q   <= '0;
      thr_q   <= THR_RESET;
      ien_q   <= 1'b0;
      pend_q  <= 1'b0;
      srcnt_q <= 3'h0;
    end else begin
      ctrl_q  <= ctrl_d;
      valid_q <= valid_d;
      chsel_q <= chsel_d;
      rpt_q   <= rpt_d;
      dly_q   <= dly_d;
      thr_q   <= thr_d;
      ien_q   <= ien_d;
      pend_q  <= pend_d;
      srcnt_q <= srcnt_d;
    end
  end

  // ------------------------------------------------------------
  // read path, one cycle latency
  // ------------------------------------------------------------
  always_comb begin
    rdata_d  = '0;
    rvalid_d = bus_rd;
    mrd_d    = bus_rd && bus_addr >= OFS_MEM;
    if (bus_rd) begin
      unique case (bus_addr)
        OFS_IRQ:   rdata_d = {30'h0, pend_q, ien_q};
        OFS_CTRL:  rdata_d = {23'h0, valid_q, 1'b0, ctrl_q};
        OFS_CHSEL: rdata_d = {16'h0, chsel_q};
        OFS_RPT:   rdata_d = {8'h0, rpt_q};
        OFS_DLY:   rdata_d = {8'h0, dly_q};
        OFS_THR:   rdata_d = {23'h0, thr_q};
        default:   rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
      mrd_q    <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      mrd_q    <= mrd_d;
    end
  end

  assign bus_rdata  = mrd_q ? {12'h0, mem_rd} : rdata_q;
  assign bus_rvalid = rvalid_q;

  // ------------------------------------------------------------
  // tick, timers and conversion sequencer
  // ------------------------------------------------------------
  always_comb begin
    tph_d  = (tph_q == 3'h4) ? 3'h0 : tph_q + 3'h1;
    rcnt_d = rcnt_q;
    dcnt_d = dcnt_q;
    st_d   = st_q;
    ch_d   = ch_q;
    xtr_d  = xs_q[2];
    xo_d   = (xt == DBS_XT_OUT) && rpt_fire;
    cv.wr   = 1'b0;
    cv.data = {ch_q, adc_data};
    if (tick && st_q != DBS_ST_IDLE) begin
      rcnt_d = (rcnt_q == rpt_q) ? 24'h0 : rcnt_q + 24'h1;
    end
    unique case (st_q)
      DBS_ST_IDLE: begin
        if (go && mode != DBS_MODE_OFF && mode != DBS_MODE_RSV) begin
          st_d   = DBS_ST_LOW;
          ch_d   = 4'h0;
          rcnt_d = 24'h0;
        end
      end
      DBS_ST_LOW, DBS_ST_HIGH: begin
        cv.wr = chsel_q[ch_q];
        ch_d  = ch_q + 4'h1;
        if (ch_q[2:0] == 3'h7) begin
          if (st_q == DBS_ST_LOW) begin
            st_d   = (chsel_q[15:8] != 8'h0) ? DBS_ST_HIGH : DBS_ST_WAIT;
            dcnt_d = 24'h0;
            if (chsel_q[15:8] != 8'h0) st_d = DBS_ST_WAIT;
          end else begin
            st_d = DBS_ST_WAIT;
          end
        end
      end
      DBS_ST_WAIT: begin
        if (ch_q == 4'h8 && tick) begin
          dcnt_d = dcnt_q + 24'h1;
          // high bank only when one of its channels is enabled
          if (dcnt_q == dly_q && chsel_q[15:8] != 8'h0) st_d = DBS_ST_HIGH;
        end
        if (mode != DBS_MODE_CONT && ch_q != 4'h8) st_d = DBS_ST_IDLE;
        if (mode != DBS_MODE_CONT && ch_q == 4'h8 && chsel_q[15:8] == 8'h0) st_d = DBS_ST_IDLE;
        if (rpt_fire) begin
          st_d = DBS_ST_LOW;
          ch_d = 4'h0;
        end
      end
      default: st_d = DBS_ST_IDLE;
    endcase
    if (mode == DBS_MODE_OFF || srst) begin
      st_d = DBS_ST_IDLE;
      rcnt_d = 24'h0;
      dcnt_d = 24'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tph_q  <= 3'h0;
      rcnt_q <= '0;
      dcnt_q <= '0;
      st_q   <= DBS_ST_IDLE;
      ch_q   <= 4'h0;
      xtr_q  <= 1'b0;
      xo_q   <= 1'b0;
    end else begin
      tph_q  <= tph_d;
      rcnt_q <= rcnt_d;
      dcnt_q <= dcnt_d;
      st_q   <= st_d;
      ch_q   <= ch_d;
      xtr_q  <= xtr_d;
      xo_q   <= xo_d;
    end
  end

  // registered pin and status outputs
  logic oe_q, irq_q, brst_q;
  logic [3:0] adc_ch_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_q     <= 1'b0;
      irq_q    <= 1'b0;
      brst_q   <= 1'b0;
      adc_ch_q <= 4'h0;
    end else begin
      oe_q     <= (xt == DBS_XT_OUT);
      irq_q    <= pend_q;
      brst_q   <= srst;
      adc_ch_q <= ch_d;
    end
  end
  assign ext_trig_oe  = oe_q;
  assign ext_trig_out = xo_q;
  assign irq          = irq_q;
  assign board_rst    = brst_q;
  assign adc_ch       = adc_ch_q;

  dbs_pingpong u_pp (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .srst    (srst),
    .cv      (cv),
    .thr     (thr_q),
    .rd_en   (bus_rd && bus_addr >= OFS_MEM),
    .rd_addr (bus_addr[10:2]),
    .rd_data (mem_rd),
    .swap    (swap)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_srst_len;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(srst) |-> srst [*3] ##1 !srst;
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("soft reset width wrong");
  property p_valid_set;
    @(posedge ref_clk) disable iff (!arst_n) (swap && !srst) |=> valid_q;
  endproperty
  a_valid_set: assert property (p_valid_set) else $error("valid flag not set");
  property p_valid_clr;
    @(posedge ref_clk) disable iff (!arst_n) (mrd_q && !swap) |=> !valid_q;
  endproperty
  a_valid_clr: assert property (p_valid_clr) else $error("valid flag not cleared");
  property p_pend_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      (pend_q && !(bus_wr && bus_addr == OFS_IRQ)) |=> pend_q;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending dropped early");
  property p_pend_set;
    @(posedge ref_clk) disable iff (!arst_n) (swap && ien_q) |=> pend_q ##1 irq;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("interrupt not raised");
  property p_astop;
    @(posedge ref_clk) disable iff (!arst_n)
      (swap && ctrl_q[CTRL_ASTOP_BIT]) |=> ctrl_q[1:0] == 2'b00;
  endproperty
  a_astop: assert property (p_astop) else $error("auto stop missed");
  property p_gate;
    @(posedge ref_clk) disable iff (!arst_n) cv.wr |-> chsel_q[cv.data[19:16]];
  endproperty
  a_gate: assert property (p_gate) else $error("disabled channel stored");
  property p_tick;
    @(posedge ref_clk) disable iff (!arst_n) !tick |=> tick [*4] ##1 !tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick pattern not four in five");
endmodule

// File: test/dbs_host.sv
module dbs_host
  import dbs_pkg::*;
(
  input  wire logic        ref_clk,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic      [11:0] bus_addr,
  output logic      [31:0] bus_wdata,
  output logic      [3:0]  bus_be,
  input  wire logic [31:0] bus_rdata,
  input  wire logic        bus_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------
  // idle bus at time zero
  // ----------------------------------------------------------
  initial begin
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_addr  = 12'h000;
    bus_wdata = 32'h0000_0000;
    bus_be    = 4'h0;
  end

  // one-cycle write strobe; released address and data show inverted values, byte enables hold
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    bus_be    <= be;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~d;
    bus_addr  <= ~a;
  endtask

  // read strobe, data taken with the one-cycle answer pulse
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    @(posedge ref_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    bus_be   <= 4'hf;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    n = 0;
    #1;
    while (bus_rvalid !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    d = (n < 4) ? bus_rdata : 32'hdead_beef;
  endtask
endmodule

// File: test/dbs_seq_tb.sv
module dbs_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dbs_pkg::*;

  logic        ref_clk;
  logic        arst_n;
  logic        bus_wr;
  logic        bus_rd;
  logic [11:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [3:0]  bus_be;
  logic [31:0] bus_rdata;
  logic        bus_rvalid;
  logic [15:0] adc_data;
  logic [3:0]  adc_ch;
  logic        ext_trig_in;
  logic        ext_trig_out;
  logic        ext_trig_oe;
  logic        irq;
  logic        board_rst;
  logic [11:0] salt;
  logic [31:0] lfsr;
  logic [31:0] rv;
  int          n_errors;
  int          samples_checked;
  int          cyc;
  int          n;
  int          cnt;
  logic [31:0] q[$];
  int          pulses[$];

  // ----------------------------------------------------------
  // design, host and converter source
  // ----------------------------------------------------------
  dbs_seq u_dbs_seq (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .bus_wr      (bus_wr),
    .bus_rd      (bus_rd),
    .bus_addr    (bus_addr),
    .bus_wdata   (bus_wdata),
    .bus_be      (bus_be),
    .bus_rdata   (bus_rdata),
    .bus_rvalid  (bus_rvalid),
    .adc_data    (adc_data),
    .adc_ch      (adc_ch),
    .ext_trig_in (ext_trig_in),
    .ext_trig_out(ext_trig_out),
    .ext_trig_oe (ext_trig_oe),
    .irq         (irq),
    .board_rst   (board_rst)
  );

  dbs_host u_dbs_host (
    .ref_clk   (ref_clk),
    .bus_wr    (bus_wr),
    .bus_rd    (bus_rd),
    .bus_addr  (bus_addr),
    .bus_wdata (bus_wdata),
    .bus_be    (bus_be),
    .bus_rdata (bus_rdata),
    .bus_rvalid(bus_rvalid)
  );

  // converter result carries its channel plus a random salt
  assign adc_data = {adc_ch, salt};

  // clock, cycle count, trigger pulse log, hang limit
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (ext_trig_out === 1'b1) pulses.push_back(cyc);
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------
  // helpers and reference model
  // ----------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    u_dbs_host.rd(a, rv);
    check(rv, exp);
  endtask

  // expected tagged samples of one or more cycles, ascending channels
  task automatic expect_cycles(input logic [15:0] sel, input int reps);
    for (int r = 0; r < reps; r++)
      for (int c = 0; c < NUM_CH; c++)
        if (sel[c]) q.push_back({12'h000, c[3:0], c[3:0], salt});
  endtask

  task automatic mem_chk;
    for (int i = 0; i < q.size(); i++) rchk(OFS_MEM + 12'(4 * i), q[i]);
    q.delete();
  endtask

  task automatic wait_valid;
    rv = 32'h0;
    for (int i = 0; i < 200 && rv[CTRL_VALID_BIT] !== 1'b1; i++) u_dbs_host.rd(OFS_CTRL, rv);
  endtask

  task automatic new_salt;
    @(posedge ref_clk);
    lfsr = lfsr_next(lfsr);
    salt <= lfsr[11:0];
  endtask

  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    ext_trig_in = 1'b0;
    salt = 12'h000;
    lfsr = 32'ha451;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    // reset values, write-only and unmapped places read zero
    rchk(OFS_IRQ, 32'h0);
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_CHSEL, 32'h0);
    rchk(OFS_RPT, 32'h0);
    rchk(OFS_DLY, 32'h0);
    rchk(OFS_THR, {23'h0, THR_RESET});
    rchk(OFS_TRIG, 32'h0);
    rchk(12'h01c, 32'h0);
    // byte lane writes merge into the stored value
    lfsr = lfsr_next(lfsr);
    u_dbs_host.wr(OFS_RPT, lfsr, 4'hf);
    u_dbs_host.wr(OFS_RPT, 32'hffff_ffff, 4'h4);
    rchk(OFS_RPT, {8'h00, 8'hff, lfsr[15:0]});
    u_dbs_host.wr(OFS_CHSEL, 32'hffff_00ff, 4'h1);
    u_dbs_host.wr(OFS_CHSEL, 32'hffff_8800, 4'h2);
    rchk(OFS_CHSEL, 32'h0000_88ff);
    // single cycle over both banks, threshold 9 -> ten samples
    new_salt();
    u_dbs_host.wr(OFS_IRQ, 32'h1, 4'hf);
    u_dbs_host.wr(OFS_DLY, 32'd63, 4'hf);
    u_dbs_host.wr(OFS_THR, 32'd9, 4'hf);
    u_dbs_host.wr(OFS_CTRL, 32'h1, 4'hf);
    u_dbs_host.wr(OFS_TRIG, 32'h1, 4'hf);
    for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge ref_clk);
    check({31'h0, irq}, 32'h1);
    rchk(OFS_IRQ, 32'h3);
    rchk(OFS_CTRL, 32'h101);
    u_dbs_host.wr(OFS_IRQ, 32'h0, 4'hf);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h1);
    expect_cycles(16'h88ff, 1);
    mem_chk();
    rchk(OFS_CTRL, 32'h001);
    u_dbs_host.wr(OFS_IRQ, 32'h8000, 4'hf);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    // continuous low bank, pin as output, stop at swap
    new_salt();
    u_dbs_host.wr(OFS_CHSEL, 32'h00ff, 4'hf);
    u_dbs_host.wr(OFS_RPT, 32'd63, 4'hf);
    u_dbs_host.wr(OFS_THR, 32'd31, 4'hf);
    u_dbs_host.wr(OFS_CTRL, 32'h62, 4'hf);
    pulses.delete();
    u_dbs_host.wr(OFS_TRIG, 32'h1, 4'hf);
    check({31'h0, ext_trig_oe}, 32'h1);
    wait_valid();
    check(rv, 32'h160);
    cnt = pulses.size();
    check(32'(cnt >= 2), 32'h1);
    if (cnt >= 2) check(32'(pulses[1] - pulses[0]), 32'd80);
    repeat (200) @(posedge ref_clk);
    check(32'(pulses.size()), 32'(cnt));
    expect_cycles(16'h00ff, 4);
    mem_chk();
    // soft reset pulse and what it clears
    u_dbs_host.wr(OFS_THR, 32'd5, 4'hf);
    u_dbs_host.wr(OFS_CTRL, 32'h8001, 4'hf);
    for (n = 0; n < 10 && board_rst !== 1'b1; n++) @(posedge ref_clk);
    for (cnt = 0; cnt < 10 && board_rst === 1'b1; cnt++) @(posedge ref_clk);
    check(32'(cnt), 32'(SRST_CYC));
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_CHSEL, 32'h0);
    rchk(OFS_THR, {23'h0, THR_RESET});
    // external trigger in: ignored while off, honoured in single mode
    new_salt();
    u_dbs_host.wr(OFS_CHSEL, 32'h0003, 4'hf);
    u_dbs_host.wr(OFS_THR, 32'd1, 4'hf);
    u_dbs_host.wr(OFS_CTRL, 32'h10, 4'hf);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      ext_trig_in <= 1'b1;
      repeat (5) @(posedge ref_clk);
      ext_trig_in <= 1'b0;
      repeat (100) @(posedge ref_clk);
      if (k == 0) rchk(OFS_CTRL, 32'h10);
      if (k == 0) u_dbs_host.wr(OFS_CTRL, 32'h11, 4'hf);
    end
    wait_valid();
    check(rv, 32'h111);
    expect_cycles(16'h0003, 1);
    mem_chk();
    test_done();
  end
endmodule
